// ### core/tmw_pkg.sv
// Constants, register map and types shared by the timer and watchdog block.
package tmw_pkg;

   localparam int unsigned SYS_CLK_NS = 25;

   localparam int EVT_W = 16;
   localparam int PER_W = 15;
   localparam int PS_W = 3;
   localparam int PER_MIN_TAP = 9;
   localparam int PER_MAX_PS = 6;

   localparam logic [7:0] ADDR_OPTION = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_INSTR = 8'h0C;
   localparam logic [7:0] ADDR_EVT_CNT = 8'h10;
   localparam logic [7:0] ADDR_PER_CNT = 8'h14;

   localparam int OPT_SEL_LO = 0;
   localparam int OPT_DIS = 2;
   localparam int OPT_PS_LO = 3;
   localparam int OPT_PMASK = 6;
   localparam int OPT_OSC_OFF = 7;
   localparam logic [7:0] OPTION_RST = 8'h7C;

   localparam int ST_EVT = 0;
   localparam int ST_PER = 1;
   localparam int ST_IRQ_OFF = 2;
   localparam int ST_IF_LO = 3;
   localparam int ST_SLEEP = 6;
   localparam int ST_WD1 = 7;
   localparam int ST_PEND = 8;

   localparam int MK_EVT = 0;
   localparam int MK_IN_LO = 1;
   localparam int MK_PIN4_DIR = 4;
   localparam logic [3:0] MASK_RST = 4'hF;

   localparam int IN_DOG_CLR = 0;
   localparam int IN_TI_CLR = 1;
   localparam int IN_OPT_LOAD = 2;
   localparam int IN_SLEEP = 3;

   localparam logic [1:0] SRC_PIN_RISE = 2'h0;
   localparam logic [1:0] SRC_PIN_FALL = 2'h1;
   localparam logic [1:0] SRC_OSC_RISE = 2'h2;
   localparam logic [1:0] SRC_IOSC_DIV4 = 2'h3;

   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [15:0] IRQ_VECTOR = 16'h0200;

   localparam int unsigned CORE_RST_NS = 100;
   localparam logic [2:0] CORE_RST_CYC = 3'((CORE_RST_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

   typedef enum logic [1:0] {
      TMW_RUN = 2'h0,
      TMW_SLEEP = 2'h1,
      TMW_WAKE = 2'h3
   } tmw_pwr_e;

   // Low counter bits that must all be ones for a periodic overflow at this prescale.
   function automatic logic [PER_W-1:0] tmw_tap_mask(input logic [PS_W-1:0] ps);
      logic [3:0] n;
      n = (ps > 3'(PER_MAX_PS)) ? 4'(PER_MAX_PS) : {1'b0, ps};
      return PER_W'((32'h1 << (PER_MIN_TAP + int'(n))) - 1);
   endfunction

endpackage

// ### core/tmw_edge.sv
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module tmw_edge import tmw_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic raw_in,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic [1:0] sync;
      logic last;
   } tmw_edge_s;

   tmw_edge_s s_q;
   tmw_edge_s s_d;

   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[0], raw_in};
      s_d.last = s_q.sync[1];
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign rise = s_q.sync[1] & ~s_q.last;
   assign fall = ~s_q.sync[1] & s_q.last;
endmodule // tmw_edge

// ### core/tmw_core.sv
// Event timer, periodic timer, watchdog and interrupt funnel behind an AHB-Lite slave.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module tmw_core import tmw_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic osc32_clk,
   input wire logic iosc_clk,
   input wire logic port_pin_four,
   input wire logic port_pin_seven,
   input wire logic irq_input_two,
   input wire logic irq_input_three,
   output logic core_irq,
   output logic [15:0] irq_vector,
   output logic core_wake,
   output logic core_reset,
   output logic inst_osc_en,
   output logic core_sleeping
);
   typedef struct packed {
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic [31:0] rdata;
      logic hready_o;
      logic [7:0] option;
      logic [PS_W-1:0] ps_active;
      logic evt_flag;
      logic per_flag;
      logic irq_off;
      logic [2:0] if_flags;
      logic [2:0] in_last;
      logic [3:0] mask;
      logic pin4_dir;
      logic [EVT_W-1:0] evt_cnt;
      logic [PER_W-1:0] per_cnt;
      logic [1:0] div4;
      logic per_pend;
      logic wd_stage1;
      logic wd_stage2;
      logic [2:0] rst_cnt;
      logic core_rst;
      tmw_pwr_e pwr;
      logic osc_en;
      logic wake;
      logic irq;
      logic [15:0] vec;
   } tmw_state_s;

   localparam tmw_state_s STATE_RST = '{option: OPTION_RST, irq_off: 1'b1, mask: MASK_RST, pin4_dir: 1'b1,
      hready_o: 1'b1, osc_en: 1'b1, vec: IRQ_VECTOR, pwr: TMW_RUN, default: '0};

   tmw_state_s s_q;
   tmw_state_s s_d;

   logic pin_rise;
   logic pin_fall;
   logic osc_rise;
   logic iosc_rise;

   // Every slow or foreign clock is sampled through a synchroniser before it touches a counter.
   tmw_edge u_pin (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .raw_in(port_pin_four),
      .rise(pin_rise), .fall(pin_fall));
   tmw_edge u_osc (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .raw_in(osc32_clk),
      .rise(osc_rise), .fall());
   tmw_edge u_iosc (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .raw_in(iosc_clk),
      .rise(iosc_rise), .fall());

   always_comb begin
      logic wr;
      logic [7:0] wdat;
      logic dog_clr;
      logic ti_clr;
      logic opt_load;
      logic sleep_cmd;
      logic evt_tick;
      logic evt_ovf;
      logic per_ovf;
      logic wd_ovf;
      logic [2:0] in_now;
      logic [2:0] in_rise;
      logic any_src;
      logic [PER_W-1:0] tap;

      evt_tick = 1'b0;
      s_d = s_q;
      s_d.wake = 1'b0;
      wdat = hwdata[7:0];
      wr = s_q.ph_valid & s_q.ph_write;
      dog_clr = wr & (s_q.ph_addr == ADDR_INSTR) & hwdata[IN_DOG_CLR];
      ti_clr = wr & (s_q.ph_addr == ADDR_INSTR) & hwdata[IN_TI_CLR];
      opt_load = wr & (s_q.ph_addr == ADDR_INSTR) & hwdata[IN_OPT_LOAD];
      sleep_cmd = wr & (s_q.ph_addr == ADDR_INSTR) & hwdata[IN_SLEEP];

      // Register writes land in the data phase; flag clears come before hardware sets.
      if (wr && s_q.ph_addr == ADDR_OPTION) begin
         s_d.option = wdat;
      end
      if (wr && s_q.ph_addr == ADDR_STATUS) begin
         s_d.evt_flag = s_q.evt_flag & ~wdat[ST_EVT];
         s_d.per_flag = s_q.per_flag & ~wdat[ST_PER];
         s_d.irq_off = wdat[ST_IRQ_OFF];
         s_d.if_flags = s_q.if_flags & ~wdat[ST_IF_LO +: 3];
      end
      if (wr && s_q.ph_addr == ADDR_MASK) begin
         s_d.mask = wdat[3:0];
         s_d.pin4_dir = wdat[MK_PIN4_DIR];
      end
      if (opt_load) begin
         s_d.ps_active = s_q.option[OPT_PS_LO +: PS_W];
      end

      // Event timer clock selection and counting.
      if (iosc_rise) begin
         s_d.div4 = s_q.div4 + 2'h1;
      end
      unique case (s_q.option[OPT_SEL_LO +: 2])
         SRC_PIN_RISE: evt_tick = pin_rise & s_q.pin4_dir;
         SRC_PIN_FALL: evt_tick = pin_fall & s_q.pin4_dir;
         SRC_OSC_RISE: evt_tick = osc_rise;
         SRC_IOSC_DIV4: evt_tick = iosc_rise & (&s_q.div4);
      endcase
      evt_tick = evt_tick & ~s_q.option[OPT_DIS];
      evt_ovf = evt_tick & (&s_q.evt_cnt);
      if (evt_tick) begin
         s_d.evt_cnt = s_q.evt_cnt + 16'h0001;
      end
      if (evt_ovf) begin
         s_d.evt_flag = 1'b1;
      end

      // Periodic timer runs from the 32 kHz oscillator regardless of sleep.
      tap = tmw_tap_mask(s_q.ps_active);
      per_ovf = osc_rise & ((s_q.per_cnt & tap) == tap);
      wd_ovf = osc_rise & (&s_q.per_cnt);
      if (osc_rise) begin
         s_d.per_cnt = s_q.per_cnt + 15'h0001;
      end
      if (ti_clr) begin
         s_d.per_pend = 1'b0;
      end
      if (per_ovf && !s_q.option[OPT_PMASK]) begin
         s_d.per_flag = 1'b1;
         s_d.per_pend = 1'b1;
      end

      // Watchdog stages; stage one is reset by the dog-clear instruction or by the overflow that toggles stage two.
      if (dog_clr) begin
         s_d.wd_stage1 = 1'b0;
      end
      if (s_q.rst_cnt != 3'h0) begin
         s_d.rst_cnt = s_q.rst_cnt - 3'h1;
      end
      if (wd_ovf) begin
         if (s_q.wd_stage1) begin
            s_d.wd_stage2 = ~s_q.wd_stage2;
            s_d.wd_stage1 = 1'b0;
            s_d.rst_cnt = CORE_RST_CYC;
         end else begin
            s_d.wd_stage1 = 1'b1;
         end
      end
      s_d.core_rst = s_d.rst_cnt != 3'h0;

      // External, serial-bus and peripheral interrupt inputs latch on rising edges.
      in_now = {irq_input_three, irq_input_two, port_pin_seven};
      in_rise = in_now & ~s_q.in_last;
      s_d.in_last = in_now;
      s_d.if_flags = s_d.if_flags | in_rise;

      // Equal priority: with irq_off clear, any enabled source raises the single request.
      any_src = (s_d.evt_flag & ~s_d.mask[MK_EVT]) | s_d.per_pend |
         (|(s_d.if_flags & ~s_d.mask[MK_IN_LO +: 3]));
      s_d.irq = any_src & ~s_d.irq_off;

      unique case (s_q.pwr)
         TMW_RUN: begin
            if (sleep_cmd) begin
               s_d.pwr = TMW_SLEEP;
               s_d.osc_en = ~s_q.option[OPT_OSC_OFF];
            end
         end
         TMW_SLEEP: begin
            if (any_src || s_d.core_rst) begin
               s_d.pwr = TMW_WAKE;
               s_d.osc_en = 1'b1;
               s_d.wake = 1'b1;
            end
         end
         TMW_WAKE: begin
            s_d.pwr = TMW_RUN;
            s_d.osc_en = 1'b1;
         end
         default: begin
            s_d.pwr = TMW_RUN;
            s_d.osc_en = 1'b1;
         end
      endcase

      // Address phase; read data is taken from the updated state so a write just before is seen.
      s_d.ph_valid = 1'b0;
      s_d.ph_write = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_d.ph_valid = 1'b1;
         s_d.ph_write = hwrite & (hsize == HSIZE_WORD);
         s_d.ph_addr = haddr[7:0];
         s_d.rdata = '0;
         if (!hwrite) begin
            unique case (haddr[7:0])
               ADDR_OPTION: s_d.rdata[7:0] = s_d.option;
               ADDR_STATUS: begin
                  s_d.rdata[ST_EVT] = s_d.evt_flag;
                  s_d.rdata[ST_PER] = s_d.per_flag;
                  s_d.rdata[ST_IRQ_OFF] = s_d.irq_off;
                  s_d.rdata[ST_IF_LO +: 3] = s_d.if_flags;
                  s_d.rdata[ST_SLEEP] = s_d.pwr == TMW_SLEEP;
                  s_d.rdata[ST_WD1] = s_d.wd_stage1;
                  s_d.rdata[ST_PEND] = s_d.per_pend;
               end
               ADDR_MASK: s_d.rdata[4:0] = {s_d.pin4_dir, s_d.mask};
               ADDR_EVT_CNT: s_d.rdata[EVT_W-1:0] = s_d.evt_cnt;
               ADDR_PER_CNT: s_d.rdata[PER_W-1:0] = s_d.per_cnt;
               default: s_d.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_q <= STATE_RST;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.hready_o;
   assign hresp = s_q.wd_stage2 & 1'b0;
   assign core_irq = s_q.irq;
   assign irq_vector = s_q.vec;
   assign core_wake = s_q.wake;
   assign core_reset = s_q.core_rst;
   assign inst_osc_en = s_q.osc_en;
   assign core_sleeping = s_q.pwr == TMW_SLEEP;
endmodule // tmw_core

// ### bench/tmw_core_checker.sv
// Concurrent checks on the timer block's ports.
`timescale 1ns/1ps
module tmw_core_checker import tmw_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [15:0] irq_vector,
   input wire logic core_wake,
   input wire logic core_reset,
   input wire logic inst_osc_en,
   input wire logic core_sleeping
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_rst_hold;
      core_reset [*4] ##1 !core_reset;
   endsequence
   sequence s_woken;
      ##1 (!core_wake && inst_osc_en && !core_sleeping);
   endsequence
   AST_VECTOR: assert property (irq_vector == IRQ_VECTOR)
      else $error("interrupt vector differs from the entry address");
   AST_READY: assert property (hreadyout)
      else $error("slave inserted a wait state");
   AST_OKAY: assert property (!hresp)
      else $error("slave answered with an error");
   AST_RDATA_HOLD: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
      else $error("read data moved without a new transfer");
   AST_RST_LEN: assert property ($rose(core_reset) |-> s_rst_hold)
      else $error("core reset pulse has the wrong length");
   AST_WAKE_STEP: assert property (core_wake |-> s_woken)
      else $error("wake did not leave sleep with the oscillator on");
   AST_WAKE_SRC: assert property (core_wake |-> core_sleeping || $past(core_sleeping))
      else $error("wake pulse seen outside sleep");
   AST_OSC_RUN: assert property (!core_sleeping |-> inst_osc_en)
      else $error("oscillator off while the core runs");
endmodule // tmw_core_checker

bind tmw_core tmw_core_checker i_chk (.sys_clk, .rstn, .hsel, .htrans, .hready, .hrdata, .hreadyout,
   .hresp, .irq_vector, .core_wake, .core_reset, .inst_osc_en, .core_sleeping);

// ### bench/tmw_core_tb.sv
// Testbench for the timer, watchdog and interrupt funnel block.
`timescale 1ns/1ps
module tmw_core_tb import tmw_pkg::*;;
   logic sys_clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic osc32_clk = 1'h0, iosc_clk = 1'h0, port_pin_four = 1'h0;
   logic [1:0] htrans = '0;
   logic [2:0] irq_in = '0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q, c;
   logic hreadyout, hresp, core_irq, core_wake, core_reset, inst_osc_en, core_sleeping;
   logic [15:0] irq_vector;
   logic [7:0] ra [5] = '{ADDR_OPTION, ADDR_STATUS, ADDR_MASK, ADDR_INSTR, 8'h20};
   logic [31:0] rv [5] = '{32'h7C, 32'h4, 32'h1F, 32'h0, 32'h0};
   int n_mismatch = 0, comparisons = 0, wakes = 0, hp = 4, j, n;

   tmw_core i_dut (.sys_clk, .rstn, .clk_en(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .osc32_clk, .iosc_clk, .port_pin_four,
      .port_pin_seven(irq_in[0]), .irq_input_two(irq_in[1]), .irq_input_three(irq_in[2]), .core_irq,
      .irq_vector, .core_wake, .core_reset, .inst_osc_en, .core_sleeping);

   initial forever #12.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) if (core_wake === 1'h1) wakes++;

   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, want %h", $time, s, e);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask

   task st;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   // Source 0/1 pulse the count pin, 2 the 32 kHz input, 3 the instruction oscillator.
   task tog(input int s, input int k);
      repeat (k) for (int v = 1; v >= 0; v--) begin
         if (s < 2) port_pin_four <= v[0];
         else if (s == 2) osc32_clk <= v[0];
         else iosc_clk <= v[0];
         repeat (hp) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
   endtask

   // Runs the periodic count up to one edge short of an overflow, then across it.
   task per(input int m);
      bus(1'h0, ADDR_PER_CNT, '0);
      j = ((m - int'(q[14:0])) & m) + 1;
      tog(2, j - 1);
      bus(1'h0, ADDR_STATUS, '0);
      chk(32'(q[1]), 32'h0);
      tog(2, 1);
      bus(1'h0, ADDR_STATUS, '0);
      chk(32'(q[1]), 32'h1);
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      void'($urandom(32'h758E));
      repeat (5) @(posedge sys_clk);
      rstn <= 1'h1;
      foreach (ra[i]) begin
         bus(1'h0, ra[i], '0);
         chk(q, rv[i]);
      end
      chk(32'(irq_vector), 32'(IRQ_VECTOR));
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         n = 1 + $urandom % 8;
         bus(1'h1, ADDR_OPTION, 32'h78 | 32'(s));
         bus(1'h0, ADDR_EVT_CNT, '0);
         c = q;
         tog(s, (s == 3) ? 4 * n : n);
         bus(1'h0, ADDR_EVT_CNT, '0);
         chk(q, (c + 32'(n)) & 32'hFFFF);
      end
      bus(1'h1, ADDR_MASK, 32'hF);
      bus(1'h1, ADDR_OPTION, 32'h78);
      tog(0, 3);
      bus(1'h1, ADDR_MASK, 32'h1F);
      bus(1'h1, ADDR_OPTION, 32'h7E);
      tog(2, 3);
      bus(1'h0, ADDR_EVT_CNT, '0);
      chk(q, c + 32'(n));
      $display("test event timer done");
      bus(1'h1, ADDR_OPTION, 32'h4);
      bus(1'h1, ADDR_INSTR, 32'h4);
      bus(1'h1, ADDR_STATUS, 32'h3F);
      bus(1'h1, ADDR_INSTR, 32'h2);
      bus(1'h1, ADDR_OPTION, 32'hC);
      per(511);
      bus(1'h0, ADDR_STATUS, '0);
      chk(q, 32'h106);
      chk(32'(core_irq), 32'h0);
      bus(1'h1, ADDR_STATUS, 32'h0);
      st;
      chk(32'(core_irq), 32'h1);
      bus(1'h1, ADDR_STATUS, 32'h2);
      st;
      chk(32'(core_irq), 32'h1);
      bus(1'h0, ADDR_STATUS, '0);
      chk(q, 32'h100);
      bus(1'h1, ADDR_INSTR, 32'h2);
      st;
      chk(32'(core_irq), 32'h0);
      bus(1'h1, ADDR_INSTR, 32'h4);
      per(1023);
      $display("test periodic timer done");
      bus(1'h1, ADDR_STATUS, 32'h3F);
      bus(1'h1, ADDR_INSTR, 32'h2);
      bus(1'h1, ADDR_OPTION, 32'h8C);
      bus(1'h1, ADDR_INSTR, 32'h8);
      st;
      chk(32'({core_sleeping, inst_osc_en}), 32'h2);
      per(1023);
      st;
      chk(32'({core_sleeping, inst_osc_en}), 32'h1);
      chk(32'(wakes), 32'h1);
      bus(1'h1, ADDR_STATUS, 32'h3F);
      bus(1'h1, ADDR_INSTR, 32'h2);
      bus(1'h1, ADDR_OPTION, 32'h4C);
      tog(2, 1024);
      bus(1'h0, ADDR_STATUS, '0);
      chk(q & 32'h102, 32'h0);
      $display("test sleep and mask done");
      bus(1'h1, ADDR_STATUS, 32'h3B);
      for (int i = 0; i < 3; i++) begin
         bus(1'h1, ADDR_MASK, 32'h1F & ~(32'h2 << i));
         @(posedge sys_clk);
         irq_in[i] <= 1'h1;
         st;
         chk(32'(core_irq), 32'h1);
         bus(1'h0, ADDR_STATUS, '0);
         chk(32'(q[5:3]), 32'h1 << i);
         irq_in[i] <= 1'h0;
         bus(1'h1, ADDR_STATUS, 32'h8 << i);
         st;
         chk(32'(core_irq), 32'h0);
      end
      bus(1'h1, ADDR_MASK, 32'h1F);
      $display("test interrupt inputs done");
      hp = 1;
      bus(1'h0, ADDR_PER_CNT, '0);
      j = 32768 - int'(q[14:0]);
      bus(1'h0, ADDR_STATUS, '0);
      chk(32'(q[7]), 32'h0);
      tog(2, j);
      bus(1'h0, ADDR_STATUS, '0);
      chk(32'(q[7]), 32'h1);
      bus(1'h1, ADDR_INSTR, 32'h4);
      bus(1'h0, ADDR_STATUS, '0);
      chk(32'(q[7]), 32'h1);
      bus(1'h1, ADDR_INSTR, 32'h1);
      bus(1'h0, ADDR_STATUS, '0);
      chk(32'(q[7]), 32'h0);
      $display("test watchdog done");
      wrap_up;
   end

   initial begin
      #(25 * 100000);
      n_mismatch++;
      wrap_up;
   end
endmodule // tmw_core_tb
